// file: dv/scc_top_sva.sv
// Checker for the sync, clamp and clock select control
`timescale 1ns/100ps
module scc_top_sva (
	// Clock, reset and register port
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// Pins and outputs
	input wire scc_pkg::scc_pins_t pins_i,
	input wire logic [1:0] green_sync_slicer_out_o,
	input wire logic [7:0] green_sync_thresh_mv_o,
	input wire scc_pkg::scc_clamp_t clamp_o,
	input wire scc_pkg::scc_clkgen_t clkgen_o
);
	logic [2:0] up_reg;
	logic hpol_reg, xcl_reg, cpol_reg, kpol_reg, yuv_reg, xclk_reg;
	logic [4:0] ph_reg;
	wire ok = up_reg == 3'h7;
	wire hs_act = pins_i.hsync == hpol_reg;
	// Skip the internal reset and synchroniser fill after each release
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			up_reg <= 3'h0;
		end else if (!ok) begin
			up_reg <= up_reg + 3'h1;
		end
	end
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			{hpol_reg, xcl_reg, cpol_reg, kpol_reg, yuv_reg, xclk_reg} <= 6'h0C;
			ph_reg <= 5'h00;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				8'h07: ph_reg <= reg_wdata_i[4:0];
				8'h0E: hpol_reg <= reg_wdata_i[6];
				8'h0F: {xcl_reg, cpol_reg, kpol_reg} <= {reg_wdata_i[7:6], reg_wdata_i[3]};
				8'h10: yuv_reg <= reg_wdata_i[0];
				8'h15: xclk_reg <= reg_wdata_i[0];
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);
	sequence s_lead;
		!hs_act ##1 hs_act;
	endsequence
	a_lock_leading: assert property (s_lead ##3 (ok && !clkgen_o.hold &&
		$past(hpol_reg, 4) == hpol_reg) |-> clkgen_o.lock_pulse)
		else $error("lock pulse missing after leading edge");
	a_lock_only: assert property (ok && clkgen_o.lock_pulse &&
		$past(hpol_reg, 4) == hpol_reg |->
		!clkgen_o.hold && $past(hs_act, 3) && !$past(hs_act, 4))
		else $error("lock pulse without leading edge");
	a_hold_coast: assert property (ok |-> clkgen_o.hold ==
		($past(pins_i.coast, 3) == $past(kpol_reg)))
		else $error("hold does not follow coast");
	a_slicer_copy: assert property (ok |->
		green_sync_slicer_out_o == $past(pins_i.green_sync, 3))
		else $error("slicer output wrong");
	a_thresh_fixed: assert property (green_sync_thresh_mv_o == 8'h96)
		else $error("slicer threshold wrong");
	a_clk_select: assert property (ok |-> clkgen_o.ext_clk_sel == $past(xclk_reg))
		else $error("clock select wrong");
	a_phase_shift: assert property (ok |->
		clkgen_o.clk_invert == $past(pins_i.invert, 3) &&
		clkgen_o.sample_phase == $past(ph_reg) + ($past(pins_i.invert, 3) ? 5'h10 : 5'h00))
		else $error("sample phase wrong");
	a_clamp_pin: assert property (ok && $past(xcl_reg) |-> clamp_o.active ==
		($past(pins_i.clamp, 3) == $past(cpol_reg)))
		else $error("external clamp wrong");
	a_clamp_level: assert property (
		clamp_o.to_ground == (clamp_o.active && !$past(yuv_reg)) &&
		clamp_o.to_midscale == (clamp_o.active && $past(yuv_reg)))
		else $error("clamp level wrong");
	a_rdata_idle: assert property (ok && !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data outside read slot");
endmodule
bind scc_top scc_top_sva chk (.clk_sys_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
	.reg_rd_i, .reg_rdata_o, .pins_i, .green_sync_slicer_out_o, .green_sync_thresh_mv_o,
	.clamp_o, .clkgen_o);

// file: dv/scc_video_src.sv
// Video source model: sync, clamp, coast and inversion pins
`timescale 1ns/100ps
module scc_video_src #(
	parameter int LINE = 39
) (
	// Clock and controls
	input wire logic clk_i,
	input wire logic hs_pol_i,
	input wire logic clamp_pol_i,
	input wire logic clamp_use_i,
	input wire logic coast_i,
	input wire logic invert_i,
	input wire logic [1:0] green_i,
	// Pins
	output scc_pkg::scc_pins_t pins_o
);
	int pos = 0;
	initial pins_o = '0;
	always @(posedge clk_i) begin
		pos <= (pos >= LINE) ? 0 : pos + 1;
		pins_o.hsync <= (pos < 4) ~^ hs_pol_i;
		// Clamp only in the back porch, where black is valid; held low when unused
		pins_o.clamp <= clamp_use_i && ((pos >= 6 && pos < 9) ~^ clamp_pol_i);
		pins_o.coast <= coast_i;
		pins_o.green_sync <= green_i;
		// Inversion moves only in blanking, so no active line is torn
		if (pos == 5) begin
			pins_o.invert <= invert_i;
		end
	end
endmodule

// file: dv/tb_sync_clamp_clock_select.sv
// Testbench for the sync, clamp and clock select control
`timescale 1ns/100ps
module tb_sync_clamp_clock_select;
	localparam int LN = 39;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_rdata_o, green_sync_thresh_mv_o, d, w;
	logic [1:0] green_sync_slicer_out_o;
	scc_pkg::scc_pins_t pins_i;
	scc_pkg::scc_clamp_t clamp_o;
	scc_pkg::scc_clkgen_t clkgen_o;
	logic hpol = 1'b0;
	logic cpol = 1'b1;
	logic cuse = 1'b1;
	logic coast = 1'b0;
	logic inv = 1'b0;
	logic [1:0] gs = 2'h0;
	logic [7:0] ra [8] = '{8'h05, 8'h06, 8'h07, 8'h0E, 8'h0F, 8'h10, 8'h15, 8'h33};
	logic [7:0] rv [8] = '{8'h08, 8'h14, 8'h00, 8'h00, 8'h48, 8'h00, 8'h00, 8'h00};
	integer seed = 81;
	int mismatches = 0;
	int checks = 0;
	int locks, clamps, mids, gnds;
	always #20 clk_sys_i = ~clk_sys_i;
	scc_top dut (.clk_sys_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .pins_i, .green_sync_slicer_out_o, .green_sync_thresh_mv_o, .clamp_o,
		.clkgen_o);
	scc_video_src #(.LINE(LN)) src (.clk_i(clk_sys_i), .hs_pol_i(hpol), .clamp_pol_i(cpol),
		.clamp_use_i(cuse), .coast_i(coast), .invert_i(inv), .green_i(gs), .pins_o(pins_i));
	function automatic logic [7:0] exp_clamps(input int n, input logic ext, input logic [7:0] w);
		return ext ? 8'(3 * n) : 8'(n * w);
	endfunction
	function automatic logic [7:0] exp_phase(input logic [4:0] p, input logic i);
		return {3'h0, p + (i ? 5'h10 : 5'h00)};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rdata_o & m, e);
	endtask
	// Whole lines only, so counts do not depend on the starting phase
	task automatic measure(input int n);
		logic [9:0] gq;
		gq = 10'h000;
		locks = 0;
		clamps = 0;
		mids = 0;
		gnds = 0;
		repeat (2 * (LN + 1)) @(posedge clk_sys_i);
		for (int j = 0; j < n * (LN + 1); j++) begin
			@(posedge clk_sys_i);
			gs <= 2'($random(seed));
			#1;
			gq = {gq[7:0], gs};
			locks += int'(clkgen_o.lock_pulse);
			clamps += int'(clamp_o.active);
			mids += int'(clamp_o.to_midscale);
			gnds += int'(clamp_o.to_ground);
			// Model stage, two sync stages and the output register
			if (j >= 4) begin
				chk({6'h00, green_sync_slicer_out_o}, {6'h00, gq[9:8]});
			end
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		mismatches++;
		results();
	end
	initial begin
		repeat (2) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		foreach (ra[i]) rd(ra[i], rv[i]);
		repeat (4) begin
			d = 8'($random(seed));
			wr(8'h07, d);
			wr(8'h33, d);
			rd(8'h07, {3'h0, d[4:0]});
			rd(8'h33, 8'h00);
		end
		chk(green_sync_thresh_mv_o, 8'h96);
		$display("test registers done");
		measure(4);
		chk(8'(locks), 8'h04);
		chk(8'(clamps), exp_clamps(4, 1'b0, 8'h14));
		chk(8'(gnds), exp_clamps(4, 1'b0, 8'h14));
		repeat (3) begin
			d = 8'($random(seed)) & 8'h0F;
			w = 8'($random(seed)) & 8'h0F;
			wr(8'h05, d);
			wr(8'h06, w);
			measure(2);
			chk(8'(clamps), exp_clamps(2, 1'b0, w));
		end
		wr(8'h06, 8'h00);
		measure(2);
		chk(8'(clamps), 8'h00);
		$display("test internal clamp done");
		wr(8'h10, 8'h01);
		for (int p = 1; p >= 0; p--) begin
			cpol <= p[0];
			wr(8'h0F, {1'b1, p[0], 6'h08});
			measure(2);
			chk(8'(clamps), exp_clamps(2, 1'b1, 8'h00));
			chk(8'(mids), exp_clamps(2, 1'b1, 8'h00));
			chk(8'(gnds), 8'h00);
		end
		$display("test external clamp done");
		wr(8'h0F, 8'h48);
		cuse <= 1'b0;
		coast <= 1'b1;
		measure(2);
		chk(8'(locks), 8'h00);
		chk({7'h00, clkgen_o.hold}, 8'h01);
		rd(8'h1F, 8'h20, 8'hE0);
		coast <= 1'b0;
		wr(8'h0F, 8'h40);
		measure(2);
		chk(8'(locks), 8'h00);
		wr(8'h0F, 8'h48);
		measure(2);
		chk(8'(locks), 8'h02);
		hpol <= 1'b1;
		wr(8'h0E, 8'h40);
		measure(2);
		chk(8'(locks), 8'h02);
		$display("test coast and sync done");
		wr(8'h15, 8'h01);
		for (int i = 1; i >= 0; i--) begin
			d = 8'($random(seed));
			wr(8'h07, d);
			inv <= i[0];
			measure(1);
			chk({7'h00, clkgen_o.ext_clk_sel}, 8'h01);
			chk({7'h00, clkgen_o.clk_invert}, {7'h00, i[0]});
			chk({3'h0, clkgen_o.sample_phase}, exp_phase(d[4:0], i[0]));
		end
		wr(8'h15, 8'h00);
		measure(1);
		chk({7'h00, clkgen_o.ext_clk_sel}, 8'h00);
		$display("test clock select done");
		results();
	end
endmodule

// file: pkg/scc_cfg.svh
// Register offsets, field positions and reset values of the sync and clamp control
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

`define SCC_ADDR_W 8
`define SCC_DATA_W 8

`define SCC_OFF_CLAMP_DELAY 8'h05
`define SCC_OFF_CLAMP_WIDTH 8'h06
`define SCC_OFF_PHASE 8'h07
`define SCC_OFF_SYNC_CTRL 8'h0E
`define SCC_OFF_CLAMP_COAST 8'h0F
`define SCC_OFF_CLAMP_LEVEL 8'h10
`define SCC_OFF_CLK_SRC 8'h15
`define SCC_OFF_STATUS 8'h1F

`define SCC_BIT_HS_POL 6
`define SCC_BIT_EXT_CLAMP 7
`define SCC_BIT_CLAMP_POL 6
`define SCC_BIT_COAST_POL 3
`define SCC_BIT_CLAMP_YUV 0
`define SCC_BIT_EXT_CLK 0

`define SCC_RST_CLAMP_DELAY 8'h08
`define SCC_RST_CLAMP_WIDTH 8'h14
`define SCC_RST_PHASE 5'h00
`define SCC_RST_HS_POL 1'b0
`define SCC_RST_EXT_CLAMP 1'b0
`define SCC_RST_CLAMP_POL 1'b1
`define SCC_RST_COAST_POL 1'b1
`define SCC_RST_CLAMP_YUV 1'b0
`define SCC_RST_EXT_CLK 1'b0

`define SCC_PHASE_W 5
`define SCC_PHASE_HALF 5'h10
`define SCC_SOG_THRESH_MV 8'h96
`define SCC_NUM_PINS 6

`endif

// file: pkg/scc_pkg.sv
// Types shared by the sync, clamp and clock select control
package scc_pkg;

	typedef struct packed {
		logic [1:0] green_sync;
		logic invert;
		logic coast;
		logic clamp;
		logic hsync;
	} scc_pins_t;

	typedef struct packed {
		logic lock_pulse;
		logic hold;
		logic ext_clk_sel;
		logic clk_invert;
		logic [4:0] sample_phase;
	} scc_clkgen_t;

	typedef struct packed {
		logic to_ground;
		logic to_midscale;
		logic active;
	} scc_clamp_t;

	typedef enum logic [1:0] {
		SCC_WIN_IDLE = 2'b00,
		SCC_WIN_DELAY = 2'b01,
		SCC_WIN_OPEN = 2'b11
	} scc_win_state_t;

endpackage

// file: src/scc_clamp_win.sv
// Internal clamp window: delay then duration counted from a start pulse
`timescale 1ns/100ps
module scc_clamp_win (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Timing
	input wire logic start_i,
	input wire logic [7:0] delay_i,
	input wire logic [7:0] width_i,
	// Window
	output logic window_o
);
	scc_pkg::scc_win_state_t state_reg;
	scc_pkg::scc_win_state_t state_next;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;

	// A new trailing edge restarts the sequence, even mid-window
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			scc_pkg::SCC_WIN_IDLE: begin
			end
			scc_pkg::SCC_WIN_DELAY: begin
				if (cnt_reg == 8'h00) begin
					state_next = (width_i == 8'h00) ? scc_pkg::SCC_WIN_IDLE
						: scc_pkg::SCC_WIN_OPEN;
					cnt_next = width_i - 8'h01;
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			scc_pkg::SCC_WIN_OPEN: begin
				if (cnt_reg == 8'h00) begin
					state_next = scc_pkg::SCC_WIN_IDLE;
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			default: begin
				state_next = scc_pkg::SCC_WIN_IDLE;
			end
		endcase
		if (start_i) begin
			state_next = scc_pkg::SCC_WIN_DELAY;
			cnt_next = delay_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= scc_pkg::SCC_WIN_IDLE;
			cnt_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	assign window_o = (state_reg == scc_pkg::SCC_WIN_OPEN);
endmodule

// file: src/scc_top.sv
// Sync-on-green slicing, clamp selection, coast and sampling clock control
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "scc_cfg.svh"
module scc_top (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Asynchronous pins
	input wire scc_pkg::scc_pins_t pins_i,
	// Sync slicer
	output logic [1:0] green_sync_slicer_out_o,
	output logic [7:0] green_sync_thresh_mv_o,
	// Clamp control
	output scc_pkg::scc_clamp_t clamp_o,
	// Clock generator control
	output scc_pkg::scc_clkgen_t clkgen_o
);
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rstn;

	logic [`SCC_NUM_PINS-1:0] pin_meta_reg;
	logic [`SCC_NUM_PINS-1:0] pin_sync_reg;
	scc_pkg::scc_pins_t pins_sync;

	logic [7:0] clamp_delay_reg;
	logic [7:0] clamp_width_reg;
	logic [`SCC_PHASE_W-1:0] phase_reg;
	logic hs_pol_reg;
	logic ext_clamp_reg;
	logic clamp_pol_reg;
	logic coast_pol_reg;
	logic clamp_yuv_reg;
	logic ext_clk_reg;

	logic hs_active;
	logic hs_prev_reg;
	logic [2:0] fill_reg;
	logic hs_lead;
	logic hs_trail;
	logic coast_active;
	logic ext_clamp_active;
	logic int_window;
	logic clamp_active;

	logic [1:0] slicer_reg;
	logic clamp_gnd_reg;
	logic clamp_mid_reg;
	logic clamp_act_reg;
	logic lock_reg;
	logic hold_reg;
	logic ext_clk_sel_reg;
	logic inv_reg;
	logic [`SCC_PHASE_W-1:0] sample_phase_reg;
	logic [`SCC_PHASE_W-1:0] sample_phase_next;

	logic wr_delay;
	logic wr_width;
	logic wr_phase;
	logic wr_sync;
	logic wr_clamp;
	logic wr_level;
	logic wr_clk;
	logic [7:0] rdata_next;
	logic [7:0] rdata_reg;

	// Reset release through two stages; assertion stays asynchronous
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign rstn = rst_sync_reg;

	// Every pin crosses two stages; only the second stage is read
	generate
		for (genvar i = 0; i < `SCC_NUM_PINS; i++) begin : g_pin_sync
			always_ff @(posedge clk_sys_i or negedge rstn) begin
				if (!rstn) begin
					pin_meta_reg[i] <= 1'b0;
					pin_sync_reg[i] <= 1'b0;
				end else begin
					pin_meta_reg[i] <= pins_i[i];
					pin_sync_reg[i] <= pin_meta_reg[i];
				end
			end
		end
	endgenerate

	assign pins_sync = pin_sync_reg;

	// Register write decode
	assign wr_delay = reg_wr_i && (reg_addr_i == `SCC_OFF_CLAMP_DELAY);
	assign wr_width = reg_wr_i && (reg_addr_i == `SCC_OFF_CLAMP_WIDTH);
	assign wr_phase = reg_wr_i && (reg_addr_i == `SCC_OFF_PHASE);
	assign wr_sync = reg_wr_i && (reg_addr_i == `SCC_OFF_SYNC_CTRL);
	assign wr_clamp = reg_wr_i && (reg_addr_i == `SCC_OFF_CLAMP_COAST);
	assign wr_level = reg_wr_i && (reg_addr_i == `SCC_OFF_CLAMP_LEVEL);
	assign wr_clk = reg_wr_i && (reg_addr_i == `SCC_OFF_CLK_SRC);

	// Clamp timing registers
	always_ff @(posedge clk_sys_i or negedge rstn) begin
		if (!rstn) begin
			clamp_delay_reg <= `SCC_RST_CLAMP_DELAY;
			clamp_width_reg <= `SCC_RST_CLAMP_WIDTH;
		end else begin
			if (wr_delay) begin
				clamp_delay_reg <= reg_wdata_i;
			end
			if (wr_width) begin
				clamp_width_reg <= reg_wdata_i;
			end
		end
	end

	// Sampling phase register
	always_ff @(posedge clk_sys_i or negedge rstn) begin
		if (!rstn) begin
			phase_reg <= `SCC_RST_PHASE;
		end else if (wr_phase) begin
			phase_reg <= reg_wdata_i[`SCC_PHASE_W-1:0];
		end
	end

	// Sync polarity register
	always_ff @(posedge clk_sys_i or negedge rstn) begin
		if (!rstn) begin
			hs_pol_reg <= `SCC_RST_HS_POL;
		end else if (wr_sync) begin
			hs_pol_reg <= reg_wdata_i[`SCC_BIT_HS_POL];
		end
	end

	// Clamp and coast control register
	always_ff @(posedge clk_sys_i or negedge rstn) begin
		if (!rstn) begin
			ext_clamp_reg <= `SCC_RST_EXT_CLAMP;
			clamp_pol_reg <= `SCC_RST_CLAMP_POL;
			coast_pol_reg <= `SCC_RST_COAST_POL;
		end else if (wr_clamp) begin
			ext_clamp_reg <= reg_wdata_i[`SCC_BIT_EXT_CLAMP];
			clamp_pol_reg <= reg_wdata_i[`SCC_BIT_CLAMP_POL];
			coast_pol_reg <= reg_wdata_i[`SCC_BIT_COAST_POL];
		end
	end

	// Clamp level and clock source registers
	always_ff @(posedge clk_sys_i or negedge rstn) begin
		if (!rstn) begin
			clamp_yuv_reg <= `SCC_RST_CLAMP_YUV;
			ext_clk_reg <= `SCC_RST_EXT_CLK;
		end else begin
			if (wr_level) begin
				clamp_yuv_reg <= reg_wdata_i[`SCC_BIT_CLAMP_YUV];
			end
			if (wr_clk) begin
				ext_clk_reg <= reg_wdata_i[`SCC_BIT_EXT_CLK];
			end
		end
	end

	// Read mux; unmapped offsets read as zero
	always_comb begin
		rdata_next = 8'h00;
		case (reg_addr_i)
			`SCC_OFF_CLAMP_DELAY: begin
				rdata_next = clamp_delay_reg;
			end
			`SCC_OFF_CLAMP_WIDTH: begin
				rdata_next = clamp_width_reg;
			end
			`SCC_OFF_PHASE: begin
				rdata_next[`SCC_PHASE_W-1:0] = phase_reg;
			end
			`SCC_OFF_SYNC_CTRL: begin
				rdata_next[`SCC_BIT_HS_POL] = hs_pol_reg;
			end
			`SCC_OFF_CLAMP_COAST: begin
				rdata_next[`SCC_BIT_EXT_CLAMP] = ext_clamp_reg;
				rdata_next[`SCC_BIT_CLAMP_POL] = clamp_pol_reg;
				rdata_next[`SCC_BIT_COAST_POL] = coast_pol_reg;
			end
			`SCC_OFF_CLAMP_LEVEL: begin
				rdata_next[`SCC_BIT_CLAMP_YUV] = clamp_yuv_reg;
			end
			`SCC_OFF_CLK_SRC: begin
				rdata_next[`SCC_BIT_EXT_CLK] = ext_clk_reg;
			end
			`SCC_OFF_STATUS: begin
				rdata_next = {inv_reg, ext_clk_sel_reg, hold_reg, clamp_act_reg,
					hs_active, ext_clamp_active, slicer_reg};
			end
			default: begin
				rdata_next = 8'h00;
			end
		endcase
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge clk_sys_i or negedge rstn) begin
		if (!rstn) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= reg_rd_i ? rdata_next : 8'h00;
		end
	end

	assign reg_rdata_o = rdata_reg;

	// Sync normalised to active high; polarity 1 means rising leading edge
	assign hs_active = pins_sync.hsync ^ ~hs_pol_reg;

	always_ff @(posedge clk_sys_i or negedge rstn) begin
		if (!rstn) begin
			hs_prev_reg <= 1'b0;
		end else begin
			hs_prev_reg <= hs_active;
		end
	end

	// Stages reset to zero, not the pin's idle level; no edges until real samples
	always_ff @(posedge clk_sys_i or negedge rstn) begin
		if (!rstn) begin
			fill_reg <= 3'h0;
		end else begin
			fill_reg <= {fill_reg[1:0], 1'b1};
		end
	end

	assign hs_lead = fill_reg[2] && hs_active && !hs_prev_reg;
	assign hs_trail = fill_reg[2] && !hs_active && hs_prev_reg;

	// Polarity 1 means active high, so a grounded unused pin never coasts
	assign coast_active = ~(pins_sync.coast ^ coast_pol_reg);
	assign ext_clamp_active = ~(pins_sync.clamp ^ clamp_pol_reg);

	// Trailing edge only times the clamp, never the lock
	scc_clamp_win u_clamp_win (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn),
		.start_i(hs_trail),
		.delay_i(clamp_delay_reg),
		.width_i(clamp_width_reg),
		.window_o(int_window)
	);

	// Pin ignored for clamping unless enabled; status bit 2 still shows it
	assign clamp_active = ext_clamp_reg ? ext_clamp_active : int_window;

	// Clamp outputs, mutually exclusive by level select
	always_ff @(posedge clk_sys_i or negedge rstn) begin
		if (!rstn) begin
			clamp_act_reg <= 1'b0;
			clamp_gnd_reg <= 1'b0;
			clamp_mid_reg <= 1'b0;
		end else begin
			clamp_act_reg <= clamp_active;
			clamp_gnd_reg <= clamp_active && !clamp_yuv_reg;
			clamp_mid_reg <= clamp_active && clamp_yuv_reg;
		end
	end

	assign clamp_o.active = clamp_act_reg;
	assign clamp_o.to_ground = clamp_gnd_reg;
	assign clamp_o.to_midscale = clamp_mid_reg;

	// Lock pulses suppressed while coasting so frequency and phase hold
	always_ff @(posedge clk_sys_i or negedge rstn) begin
		if (!rstn) begin
			lock_reg <= 1'b0;
			hold_reg <= 1'b0;
		end else begin
			lock_reg <= hs_lead && !coast_active;
			hold_reg <= coast_active;
		end
	end

	// Phase offset kept on either clock source; inversion adds half a period
	always_comb begin
		sample_phase_next = phase_reg;
		if (pins_sync.invert) begin
			sample_phase_next = phase_reg + `SCC_PHASE_HALF;
		end
	end

	// Inversion is taken as is; glitch-free timing is the controller's job
	always_ff @(posedge clk_sys_i or negedge rstn) begin
		if (!rstn) begin
			ext_clk_sel_reg <= `SCC_RST_EXT_CLK;
			inv_reg <= 1'b0;
			sample_phase_reg <= `SCC_RST_PHASE;
		end else begin
			ext_clk_sel_reg <= ext_clk_reg;
			inv_reg <= pins_sync.invert;
			sample_phase_reg <= sample_phase_next;
		end
	end

	assign clkgen_o.lock_pulse = lock_reg;
	assign clkgen_o.hold = hold_reg;
	assign clkgen_o.ext_clk_sel = ext_clk_sel_reg;
	assign clkgen_o.clk_invert = inv_reg;
	assign clkgen_o.sample_phase = sample_phase_reg;

	// Comparator results passed through uninverted
	always_ff @(posedge clk_sys_i or negedge rstn) begin
		if (!rstn) begin
			slicer_reg <= 2'h0;
		end else begin
			slicer_reg <= pins_sync.green_sync;
		end
	end

	assign green_sync_slicer_out_o = slicer_reg;
	// Slicing level above the negative peak, for the analog comparator
	assign green_sync_thresh_mv_o = `SCC_SOG_THRESH_MV;
endmodule
